// File: shared/oscc_defs.vh
// Constants for the oscillator enable and status control block.
// Assumes inclusion by bare name from the design files.
`ifndef OSCC_DEFS_VH
`define OSCC_DEFS_VH

// Byte addresses of the registers.
`define OSCC_KEY_ADDR 16'h0a0c
`define OSCC_CTRL_ADDR 16'h0a10
`define OSCC_HPCFG_ADDR 16'h20bc
`define OSCC_IRQ_STAT_ADDR 16'h0a20
`define OSCC_IRQ_MASK_ADDR 16'h0a24
`define OSCC_SYSRST_ADDR 16'h0a28

// Unlock key value.
`define OSCC_KEY_VALUE 16'hcb14

// Field positions in the control register.
`define OSCC_LF_EN_BIT 0
`define OSCC_HF_EN_BIT 1
`define OSCC_XT_EN_BIT 2
`define OSCC_LF_RDY_BIT 8
`define OSCC_HF_RDY_BIT 9
`define OSCC_XT_RDY_BIT 10

// Reset values.
`define OSCC_EN_RESET 3'h3
`define OSCC_HPCFG_RESET 32'h00000034

// Stabilisation time in microseconds and clock rate in MHz.
`define OSCC_STAB_US 10
`define OSCC_CLK_MHZ 25
`define OSCC_STAB_CYCLES (`OSCC_STAB_US * `OSCC_CLK_MHZ)

`endif

// File: src/oscc_stab_timer.v
// Stabilisation timer for one oscillator.
// Assumes enable is a level from the control register in the clk domain.
`timescale 1ns/1ps
module oscc_stab_timer #(
	parameter CYCLES = 250,
	parameter CW = 16
) (
	input wire clk,
	input wire reset,
	input wire enable,
	output reg ready_reg
);
	reg [CW-1:0] count_reg;

	// Count from enable; clear at once on disable; ready is latched.
	always @(posedge clk) begin
		if (reset || !enable) begin
			count_reg <= {CW{1'b0}};
			ready_reg <= 1'b0;
		end else if (!ready_reg) begin
			if (count_reg == CYCLES[CW-1:0] - 1'b1) begin
				ready_reg <= 1'b1;
			end else begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end
endmodule // oscc_stab_timer

// File: src/oscc_top.v
// Oscillator enable and status control with an Avalon-MM slave.
// Assumes a synchronous master; one access answered per request.
`timescale 1ns/1ps
`include "oscc_defs.vh"
module oscc_top #(
	parameter STAB_CYCLES = `OSCC_STAB_CYCLES
) (
	input wire clk,
	input wire reset,
	input wire [15:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg lf_osc_enable,
	output reg hf_osc_enable,
	output reg xtal_osc_enable,
	output reg system_reset_request,
	output reg irq
);
	////////////////////////////////////////////////////////////////////
	// Reset value of the three enable bits, taken apart per oscillator.
	localparam [2:0] EN_RST = `OSCC_EN_RESET;

	// Control, configuration and event state.
	reg [2:0] en_reg;
	reg unlock_reg;
	reg [31:0] hpcfg_reg;
	reg [2:0] stat_reg;
	reg [2:0] mask_reg;
	reg [2:0] rdy_prev_reg;
	reg done_reg;

	// Timer flags, bus qualifiers and word decodes.
	wire [2:0] rdy;
	wire req;
	wire wr_now;
	wire [2:0] rise;
	wire sel_key;
	wire sel_ctrl;
	wire sel_hpcfg;
	wire sel_stat;
	wire sel_mask;
	wire sel_sysrst;
	wire key_ok;
	wire ctrl_wr;
	wire srr_ok;

	// Address match on the word part; the two byte bits are ignored.
	function hit;
		input [15:0] a;
		input [15:0] b;
		begin
			hit = (a[15:2] == b[15:2]);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// One stabilisation timer per oscillator; its flag is latched.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_tmr
			oscc_stab_timer #(.CYCLES(STAB_CYCLES), .CW(16)) u_tmr (
				.clk(clk),
				.reset(reset),
				.enable(en_reg[g]),
				.ready_reg(rdy[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// A request is taken once and completes on the following edge.
	assign req = (avs_read || avs_write) && !done_reg;
	assign wr_now = avs_write && done_reg;

	// A ready flag that rises is an event for the status register.
	assign rise = rdy & ~rdy_prev_reg;

	// Word decodes shared by the write and read paths.
	assign sel_key = hit(avs_address, `OSCC_KEY_ADDR);
	assign sel_ctrl = hit(avs_address, `OSCC_CTRL_ADDR);
	assign sel_hpcfg = hit(avs_address, `OSCC_HPCFG_ADDR);
	assign sel_stat = hit(avs_address, `OSCC_IRQ_STAT_ADDR);
	assign sel_mask = hit(avs_address, `OSCC_IRQ_MASK_ADDR);
	assign sel_sysrst = hit(avs_address, `OSCC_SYSRST_ADDR);

	// Only the exact key in the low half opens the control register.
	assign key_ok = sel_key && (avs_writedata[15:0] == `OSCC_KEY_VALUE);

	// A control write needs the open lock and the low byte lane.
	assign ctrl_wr = wr_now && sel_ctrl && unlock_reg &&
		avs_byteenable[0];

	// A system reset is refused unless both fast sources are enabled.
	assign srr_ok = en_reg[`OSCC_XT_EN_BIT] && en_reg[`OSCC_HF_EN_BIT];

	////////////////////////////////////////////////////////////////////
	// Handshake: waitrequest low for one cycle after a request is seen.
	always @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			done_reg <= req;
			avs_waitrequest <= !req;
		end
	end

	// Any completed write consumes the lock; only a key write reopens it.
	always @(posedge clk) begin
		if (reset) begin
			unlock_reg <= 1'b0;
		end else if (wr_now) begin
			unlock_reg <= key_ok;
		end
	end

	// Enable bits; a write while locked leaves them as they are.
	always @(posedge clk) begin
		if (reset) begin
			en_reg <= EN_RST;
		end else if (ctrl_wr) begin
			en_reg <= avs_writedata[2:0];
		end
	end

	// High-power configuration word; it needs no key.
	always @(posedge clk) begin
		if (reset) begin
			hpcfg_reg <= `OSCC_HPCFG_RESET;
		end else if (wr_now && sel_hpcfg) begin
			hpcfg_reg <= avs_writedata;
		end
	end

	// Interrupt mask, one bit per ready event.
	always @(posedge clk) begin
		if (reset) begin
			mask_reg <= 3'h0;
		end else if (wr_now && sel_mask) begin
			mask_reg <= avs_writedata[2:0];
		end
	end

	// Sticky ready events; a rise in the cycle of a clear still sets.
	always @(posedge clk) begin
		if (reset) begin
			rdy_prev_reg <= 3'h0;
			stat_reg <= 3'h0;
		end else begin
			rdy_prev_reg <= rdy;
			// Writing ones clears those bits.
			if (wr_now && sel_stat) begin
				stat_reg <= (stat_reg & ~avs_writedata[2:0]) | rise;
			end else begin
				stat_reg <= stat_reg | rise;
			end
		end
	end

	// One-cycle system reset request, only with both fast sources on.
	always @(posedge clk) begin
		if (reset) begin
			system_reset_request <= 1'b0;
		end else begin
			system_reset_request <= wr_now && sel_sysrst &&
				avs_writedata[0] && srr_ok;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data are taken on the taking edge and stand until the next read.
	always @(posedge clk) begin
		if (reset) begin
			avs_readdata <= 32'h0;
		end else if (req && avs_read) begin
			if (sel_ctrl) begin
				avs_readdata <= {21'h0, rdy[2], rdy[1], rdy[0], 5'h0,
					en_reg};
			end else if (sel_key) begin
				// The key reads back as zero so it cannot be learnt.
				avs_readdata <= 32'h0;
			end else if (sel_hpcfg) begin
				avs_readdata <= hpcfg_reg;
			end else if (sel_stat) begin
				avs_readdata <= {29'h0, stat_reg};
			end else if (sel_mask) begin
				avs_readdata <= {29'h0, mask_reg};
			end else begin
				avs_readdata <= 32'h0;
			end
		end
	end

	// Registered outputs to the oscillators and the interrupt line.
	always @(posedge clk) begin
		if (reset) begin
			lf_osc_enable <= EN_RST[`OSCC_LF_EN_BIT];
			hf_osc_enable <= EN_RST[`OSCC_HF_EN_BIT];
			xtal_osc_enable <= EN_RST[`OSCC_XT_EN_BIT];
			irq <= 1'b0;
		end else begin
			lf_osc_enable <= en_reg[`OSCC_LF_EN_BIT];
			hf_osc_enable <= en_reg[`OSCC_HF_EN_BIT];
			xtal_osc_enable <= en_reg[`OSCC_XT_EN_BIT];
			// The interrupt is a level that follows the masked status.
			irq <= |(stat_reg & mask_reg);
		end
	end
endmodule // oscc_top

// File: tb/oscc_props.sv
// Checker for the oscillator control block, watching its top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module oscc_props #(
	parameter STAB_CYCLES = 250
) (
	input wire clk,
	input wire reset,
	input wire [15:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire lf_osc_enable,
	input wire hf_osc_enable,
	input wire xtal_osc_enable,
	input wire system_reset_request,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Bus answers after one wait cycle, low for one cycle only.
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("late bus answer");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	AST_RESET_EN: assert property ($fell(reset) |-> lf_osc_enable &&
		hf_osc_enable && !xtal_osc_enable) else $error("bad enable reset");
	AST_RESET_OUT: assert property ($fell(reset) |-> !irq &&
		!system_reset_request && avs_waitrequest) else $error("bad reset");
	AST_SRR_GUARD: assert property (system_reset_request |->
		xtal_osc_enable && hf_osc_enable) else $error("reset without enables");
	AST_SRR_PULSE: assert property (system_reset_request |=>
		!system_reset_request) else $error("reset request too long");
	AST_EN_BY_WRITE: assert property ($changed({lf_osc_enable,
		hf_osc_enable, xtal_osc_enable}) |-> $past(avs_write, 2) ||
		$past(avs_write, 3)) else $error("enable moved without write");
	AST_RD_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without read");
	// Main scenarios seen.
	cover property (system_reset_request);
	cover property (irq);
	cover property ($fell(lf_osc_enable));
endmodule // oscc_props
////////////////////////////////////////////////////////////////////////////
bind oscc_top oscc_props #(.STAB_CYCLES(STAB_CYCLES)) u_props (.clk(clk),
	.reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .lf_osc_enable(lf_osc_enable),
	.hf_osc_enable(hf_osc_enable), .xtal_osc_enable(xtal_osc_enable),
	.system_reset_request(system_reset_request), .irq(irq));

// File: tb/oscc_top_tb.sv
// Self-checking bench for the oscillator control block.
// Assumes a fixed one-cycle bus wait and stabilisation shortened to 4.
`timescale 1ns/1ps
module oscc_top_tb;
	logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
	logic [15:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rdat;
	logic avs_waitrequest, lf, hf, xt, srr, irq;
	int errors = 0, compares = 0, pulses = 0;
	// Rows: write flag, irq expected, address, write data or read expected.
	logic [55:0] rows [] = '{56'h000a1000000303, 56'h0020bc00000034,
		56'h1020bc000000a5, 56'h0020bc000000a5, 56'h100a1000000004,
		56'h000a1000000303, 56'h100a0c0000cb14, 56'h1020bc00000034,
		56'h100a1000000004, 56'h000a1000000303, 56'h100a0c0000cb14,
		56'h100a1000000004, 56'h000a1000000404, 56'h110a2400000007,
		56'h010a2000000007, 56'h100a2000000007, 56'h000a2000000000,
		56'h000f0000000000, 56'h100a2800000001, 56'h100a0c0000cb14,
		56'h110a1000000006, 56'h010a1000000606, 56'h110a2800000001};
	oscc_top #(.STAB_CYCLES(4)) dut (.clk(clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.lf_osc_enable(lf), .hf_osc_enable(hf), .xtal_osc_enable(xt),
		.system_reset_request(srr), .irq(irq));
	always #20 clk = ~clk;
	// Counts reset request pulses.
	always @(posedge clk) if (srr === 1'b1) pulses <= pulses + 1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus access, held until waitrequest is seen low.
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rdat = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
	endtask
	task tally_and_finish;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#50us;
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		repeat (10) @(posedge clk);
		foreach (rows[i]) begin
			acc(rows[i][52], rows[i][47:32], rows[i][31:0]);
			if (!rows[i][52]) chk(rdat, rows[i][31:0]);
			repeat (10) @(posedge clk);
			chk(irq, rows[i][48]);
		end
		chk(pulses, 1);
		$display("table test done");
		// Reset in mid-run restores enables and the configuration value.
		reset <= 1;
		repeat (3) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		chk({xt, hf, lf}, 3'h3);
		acc(0, 16'h20bc, 0);
		chk(rdat, 32'h34);
		// Software waits out the stabilisation before trusting a source.
		repeat (4) @(posedge clk);
		acc(0, 16'h0a10, 0);
		chk(rdat, 32'h303);
		$display("reset test done");
		tally_and_finish;
	end
endmodule // oscc_top_tb
